// File: home_switch_homing_seq.sv
// Purpose: Home-switch homing sequencer for methods 24 to 27
// Assumes: Switch inputs are debounced and synchronous to core_clk
// Notes:   Deceleration itself is done by the motion loop
`timescale 1ns/1ps
`default_nettype none
`include "homing_defs.svh"
module home_switch_homing_seq #(
  parameter int SPD_W = 32,
  parameter int POS_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic homeSw,
  input wire logic fwdLimit,
  input wire logic revLimit,
  input wire logic [7:0] method,
  input wire logic [15:0] ctrlWord,
  input wire logic [SPD_W-1:0] fastSpeed,
  input wire logic [SPD_W-1:0] slowSpeed,
  input wire logic [POS_W-1:0] actualPos,
  output var homing_pkg::motion_type motion,
  output logic [SPD_W-1:0] speedCmd,
  output logic [POS_W-1:0] zeroPos,
  output logic homeDone,
  output logic methodErr
);
  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  homing_pkg::state_type state_r;
  homing_pkg::motion_type motion_r;
  logic homePrev_r;
  logic [15:0] cwPrev_r;
  logic homeRise;
  logic homeFall;
  logic startReq;
  logic methodOk;
  logic captureEdge;

  function automatic logic isMethod(input logic [7:0] m,
                                    input logic [7:0] code);
    isMethod = (m == code);
  endfunction

  assign homeRise = homeSw && !homePrev_r;
  assign homeFall = !homeSw && homePrev_r;
  // Only the enabled-to-start step launches a run
  assign startReq = (cwPrev_r == `HOM_CW_ENABLED) &&
                    (ctrlWord == `HOM_CW_START);
  assign methodOk = isMethod(method, `HOM_METHOD_24) ||
                    isMethod(method, `HOM_METHOD_25) ||
                    isMethod(method, `HOM_METHOD_26) ||
                    isMethod(method, `HOM_METHOD_27);
  // Final pass: 24/25 take the rise, 26/27 the fall
  assign captureEdge = (isMethod(method, `HOM_METHOD_24) ||
                        isMethod(method, `HOM_METHOD_25)) ? homeRise
                                                          : homeFall;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      homePrev_r <= 1'b0;
      cwPrev_r <= 16'h0000;
    end else begin
      homePrev_r <= homeSw;
      cwPrev_r <= ctrlWord;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Method is assumed stable during a run; it is not latched
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= homing_pkg::S_IDLE;
      motion_r <= '0;
    end else if (startReq && methodOk) begin
      if (!homeSw) begin
        state_r <= homing_pkg::S_SEARCH;
        // 27 searches in reverse, the rest forward
        motion_r <= '{run: 1'b1,
                      dirFwd: !isMethod(method, `HOM_METHOD_27),
                      fast: 1'b1};
      end else if (isMethod(method, `HOM_METHOD_24)) begin
        state_r <= homing_pkg::S_PRE;
        motion_r <= '{run: 1'b1, dirFwd: 1'b0, fast: 1'b0};
      end else if (isMethod(method, `HOM_METHOD_25)) begin
        state_r <= homing_pkg::S_PRE;
        motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b0};
      end else begin
        state_r <= homing_pkg::S_APPROACH;
        motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b0};
      end
    end else begin
      case (state_r)
        homing_pkg::S_SEARCH: begin
          if (homeRise) begin
            if (isMethod(method, `HOM_METHOD_24) ||
                isMethod(method, `HOM_METHOD_25)) begin
              state_r <= homing_pkg::S_DONE;
              motion_r <= '0;
            end else begin
              state_r <= homing_pkg::S_APPROACH;
              motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b0};
            end
          end else if (motion_r.dirFwd && fwdLimit) begin
            state_r <= homing_pkg::S_BACK;
            motion_r <= '{run: 1'b1, dirFwd: 1'b0, fast: 1'b1};
          end else if (!motion_r.dirFwd && revLimit) begin
            state_r <= homing_pkg::S_BACK;
            motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b1};
          end
        end
        homing_pkg::S_BACK: begin
          if (homeRise) begin
            if (isMethod(method, `HOM_METHOD_24)) begin
              state_r <= homing_pkg::S_DONE;
              motion_r <= '0;
            end else if (isMethod(method, `HOM_METHOD_25)) begin
              state_r <= homing_pkg::S_PRE;
              motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b0};
            end else begin
              state_r <= homing_pkg::S_APPROACH;
              motion_r <= '{run: 1'b1, dirFwd: 1'b1, fast: 1'b0};
            end
          end
        end
        homing_pkg::S_PRE: begin
          if (homeFall) begin
            state_r <= homing_pkg::S_APPROACH;
            motion_r <= '{run: 1'b1,
                          dirFwd: isMethod(method, `HOM_METHOD_24),
                          fast: 1'b0};
          end
        end
        homing_pkg::S_APPROACH: begin
          if (captureEdge) begin
            state_r <= homing_pkg::S_DONE;
            motion_r <= '0;
          end
        end
        homing_pkg::S_IDLE: begin
          state_r <= homing_pkg::S_IDLE;
        end
        homing_pkg::S_DONE: begin
          state_r <= homing_pkg::S_DONE;
        end
        default: begin
          state_r <= homing_pkg::S_IDLE;
          motion_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Capture, done and speed
  // ----------------------------------------------------------------
  logic capture;
  assign capture = (state_r == homing_pkg::S_APPROACH && captureEdge) ||
                   (state_r == homing_pkg::S_SEARCH && homeRise &&
                    (isMethod(method, `HOM_METHOD_24) ||
                     isMethod(method, `HOM_METHOD_25))) ||
                   (state_r == homing_pkg::S_BACK && homeRise &&
                    isMethod(method, `HOM_METHOD_24));

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      zeroPos <= POS_W'(`HOM_POS_RESET);
      homeDone <= 1'b0;
    end else if (capture && !(startReq && methodOk)) begin
      // Refused start leaves the run alone, so its capture still lands
      zeroPos <= actualPos;
      homeDone <= 1'b1;
    end else if (startReq) begin
      homeDone <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      methodErr <= 1'b0;
    end else if (startReq) begin
      methodErr <= !methodOk;
    end
  end

  // Speed follows the motion register one cycle later
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      speedCmd <= '0;
    end else if (!motion_r.run) begin
      speedCmd <= '0;
    end else begin
      speedCmd <= motion_r.fast ? fastSpeed : slowSpeed;
    end
  end

  assign motion = motion_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  start_low24_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    startReq && isMethod(method, `HOM_METHOD_24) && !homeSw |=>
    motion.run && motion.dirFwd && motion.fast)
    else $error("M24 low start not fast forward");
  limit_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_SEARCH && !homeRise && fwdLimit &&
    motion.dirFwd && !startReq |=> state_r == homing_pkg::S_BACK &&
    !motion.dirFwd && motion.fast)
    else $error("Forward limit did not reverse fast");
  pre24_rev_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    startReq && isMethod(method, `HOM_METHOD_24) && homeSw |=>
    state_r == homing_pkg::S_PRE && !motion.dirFwd && !motion.fast)
    else $error("M24 high start not slow reverse");
  m25_pre_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_PRE && homeFall && !startReq &&
    isMethod(method, `HOM_METHOD_25) |=> !motion.dirFwd && motion.run)
    else $error("M25 did not reverse after fall");
  rev27_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_SEARCH && !motion.dirFwd && revLimit &&
    !homeRise && !startReq |=> motion.dirFwd && motion.fast)
    else $error("Reverse limit did not turn forward");
  slow26_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    startReq && homeSw && (isMethod(method, `HOM_METHOD_26) ||
    isMethod(method, `HOM_METHOD_27)) |=>
    state_r == homing_pkg::S_APPROACH && !motion.fast)
    else $error("M26/27 high start not slow approach");
  speed_pick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    motion.run && motion.fast |=>
    speedCmd == $past(fastSpeed))
    else $error("Fast speed not taken");
  capture_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    capture && !startReq |=> homeDone && !motion.run &&
    zeroPos == $past(actualPos) ##1 speedCmd == '0)
    else $error("Capture did not stop and latch");
  done_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    homeDone && !startReq |=> homeDone)
    else $error("Done dropped without start");
  m26_fall_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_APPROACH &&
    isMethod(method, `HOM_METHOD_26) && !startReq |=>
    homeDone == $past(homeFall))
    else $error("M26 captured on a rise");

  cov_done_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    $rose(homeDone));
  cov_back_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_BACK ##[1:1000] $rose(homeDone));
  cov_pre_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    state_r == homing_pkg::S_PRE ##1 state_r == homing_pkg::S_APPROACH);
  cov_err_c: cover property (@(posedge core_clk) disable iff (!rst_b)
    methodErr);
endmodule
`default_nettype wire

// File: homing_defs.svh
// Purpose: Constants for the home-switch homing sequencer
// Assumes: Inputs synchronous to core_clk (250 MHz)
// Notes:   Method codes and control word values are plain numbers
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH
`define HOM_METHOD_24 8'h18
`define HOM_METHOD_25 8'h19
`define HOM_METHOD_26 8'h1A
`define HOM_METHOD_27 8'h1B
`define HOM_CW_ENABLED 16'h000F
`define HOM_CW_START 16'h001F
`define HOM_POS_RESET 32'h0000_0000
`endif

// File: homing_partner.sv
// Purpose: Axis and switch model facing the homing sequencer
// Assumes: One count of travel per cycle while the motion command runs
// Notes:   Switches are pure functions of position, so edges land exactly
`timescale 1ns/1ps
`default_nettype none
module homing_partner #(
  parameter int HOME_LO = 100,
  parameter int HOME_HI = 120,
  parameter int LIM_F = 200,
  parameter int LIM_R = 20
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire homing_pkg::motion_type motion,
  input wire logic loadPos,
  input wire logic [31:0] startPos,
  output logic [31:0] actualPos,
  output logic homeSw,
  output logic fwdLimit,
  output logic revLimit
);
  // ----------------------------------------
  // Axis travel
  // ----------------------------------------
  // Same step for fast and slow keeps edge positions exact
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      actualPos <= 32'h0000_0000;
    end else if (loadPos) begin
      actualPos <= startPos;
    end else if (motion.run) begin
      actualPos <= motion.dirFwd ? actualPos + 1 : actualPos - 1;
    end
  end
  // ----------------------------------------
  // Switch levels
  // ----------------------------------------
  assign homeSw = (actualPos >= HOME_LO) && (actualPos <= HOME_HI);
  assign fwdLimit = actualPos >= LIM_F;
  assign revLimit = actualPos <= LIM_R;
endmodule
`default_nettype wire

// File: homing_pkg.sv
// Purpose: Types for the home-switch homing sequencer
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Motion command travels as one packed struct
package homing_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_SEARCH, S_BACK, S_PRE, S_APPROACH, S_DONE
  } state_type;
  typedef struct packed {
    logic run;
    logic dirFwd;
    logic fast;
  } motion_type;
endpackage

// File: tb_top.sv
// Purpose: Self-checking bench for the home-switch homing sequencer
// Assumes: Partner axis with home window 100..120, limits at 20 and 200
// Notes:   Inputs change on the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
`include "homing_defs.svh"
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin \
  num_errors++; $display("[ERR] %0t act=%0h exp=%0h", $time, act, exp); \
  end end
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] method = `HOM_METHOD_24;
  logic [15:0] ctrlWord = 16'h0000;
  logic [31:0] fastSpeed = 32'h0000_0500;
  logic [31:0] slowSpeed = 32'h0000_0030;
  logic loadPos = 1'b0;
  logic [31:0] startPos = 32'h0000_0000;
  logic [31:0] actualPos, speedCmd, zeroPos;
  logic homeSw, fwdLimit, revLimit, homeDone, methodErr;
  homing_pkg::motion_type motion;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 core_clk = ~core_clk;
  home_switch_homing_seq i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .homeSw(homeSw), .fwdLimit(fwdLimit), .revLimit(revLimit),
    .method(method), .ctrlWord(ctrlWord), .fastSpeed(fastSpeed),
    .slowSpeed(slowSpeed), .actualPos(actualPos), .motion(motion),
    .speedCmd(speedCmd), .zeroPos(zeroPos), .homeDone(homeDone),
    .methodErr(methodErr));
  homing_partner i_axis (.core_clk(core_clk), .rst_b(rst_b),
    .motion(motion), .loadPos(loadPos), .startPos(startPos),
    .actualPos(actualPos), .homeSw(homeSw), .fwdLimit(fwdLimit),
    .revLimit(revLimit));
  // ----------------------------------------
  // Shared steps
  // ----------------------------------------
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bench drives the given pre word, then start, then enabled on the control word
  task automatic start(input logic [7:0] m, input logic [31:0] sp,
                       input logic [15:0] pre);
    @(negedge core_clk);
    method = m;
    startPos = sp;
    loadPos = 1'b1;
    ctrlWord = pre;
    @(negedge core_clk);
    loadPos = 1'b0;
    ctrlWord = `HOM_CW_START;
    @(negedge core_clk);
    ctrlWord = `HOM_CW_ENABLED;
    @(negedge core_clk);
  endtask
  // Checks first command and speed, then the captured zero and the stop
  task automatic home_run(input logic [7:0] m, input logic [31:0] sp,
                          input logic [31:0] ez, input logic df,
                          input logic fs);
    int n;
    start(m, sp, `HOM_CW_ENABLED);
    `CHK(motion, {1'b1, df, fs})
    `CHK(homeDone, 1'b0)
    @(negedge core_clk);
    `CHK(speedCmd, fs ? fastSpeed : slowSpeed)
    n = 0;
    while (homeDone !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(zeroPos, ez)
    repeat (3) @(negedge core_clk);
    `CHK({motion.run, speedCmd, homeDone}, {1'b0, 32'h0000_0000, 1'b1})
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_m24();
    home_run(`HOM_METHOD_24, 60, 100, 1'b1, 1'b1);
    home_run(`HOM_METHOD_24, 150, 120, 1'b1, 1'b1);
    home_run(`HOM_METHOD_24, 110, 100, 1'b0, 1'b0);
  endtask
  task automatic t_m25();
    home_run(`HOM_METHOD_25, 60, 100, 1'b1, 1'b1);
    home_run(`HOM_METHOD_25, 150, 120, 1'b1, 1'b1);
    home_run(`HOM_METHOD_25, 110, 120, 1'b1, 1'b0);
  endtask
  task automatic t_m26();
    home_run(`HOM_METHOD_26, 60, 121, 1'b1, 1'b1);
    home_run(`HOM_METHOD_26, 150, 121, 1'b1, 1'b1);
    home_run(`HOM_METHOD_26, 110, 121, 1'b1, 1'b0);
  endtask
  task automatic t_m27();
    home_run(`HOM_METHOD_27, 150, 121, 1'b0, 1'b1);
    home_run(`HOM_METHOD_27, 60, 121, 1'b0, 1'b1);
    home_run(`HOM_METHOD_27, 110, 121, 1'b1, 1'b0);
  endtask
  // Unknown method is refused and nothing moves
  task automatic t_bad_method();
    start(8'h17, 60, `HOM_CW_ENABLED);
    `CHK({methodErr, motion.run}, 2'b10)
    `CHK(homeDone, 1'b0)
  endtask
  // Start bit without the enabled word first must not start
  task automatic t_no_enable();
    start(`HOM_METHOD_24, 60, 16'h0000);
    repeat (2) @(negedge core_clk);
    `CHK(motion.run, 1'b0)
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    `CHK({motion, speedCmd, zeroPos, homeDone, methodErr}, 69'h0)
    t_m24();
    t_m25();
    t_m26();
    t_m27();
    t_bad_method();
    t_no_enable();
    test_done();
  end
endmodule
`default_nettype wire
